// File: design/rtcsa_pkg.sv
// Package of constants and carrier types for the second and alarm counter block.
package rtcsa_pkg;

  // Register indices; the AXI byte address is four times the index.
  localparam logic [21:0] IDX_SEC_BYTE0 = 22'h0a0008;
  localparam logic [21:0] IDX_SEC_BYTE1 = 22'h00a009;
  localparam logic [21:0] IDX_SEC_BYTE2 = 22'h00a00a;
  localparam logic [21:0] IDX_SEC_BYTE3 = 22'h00a00b;
  localparam logic [21:0] IDX_CTRL = 22'h00a00c;
  localparam logic [21:0] IDX_CMD = 22'h00a00d;
  localparam logic [21:0] IDX_IRQ_STATUS = 22'h00a00e;
  localparam logic [21:0] IDX_IRQ_CLEAR = 22'h00a00f;
  localparam logic [21:0] IDX_IRQ_ENABLE = 22'h00a010;

  // Widths of the counting chain.
  localparam int DIV_WIDTH = 16;
  localparam int SEC_WIDTH = 30;
  localparam int QUARTER_BITS = 13;
  localparam int SECOND_BITS = 15;

  // Control register field positions.
  localparam int CTRL_SEC_EN = 7;
  localparam int CTRL_ALM_EN = 6;
  localparam int CTRL_SEC_FLAG = 5;
  localparam int CTRL_ALM_FLAG = 4;
  localparam int CTRL_QTR_EN = 3;
  localparam int CTRL_QTR_FLAG = 2;

  // Interrupt status, clear and enable bit positions.
  localparam int IRQ_SEC = 0;
  localparam int IRQ_ALM = 1;
  localparam int IRQ_QTR = 2;

  // Command register clear bit.
  localparam int CMD_CLEAR = 0;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  localparam logic [29:0] ALARM_RESET = 30'h00000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    REG_SEC0, REG_SEC1, REG_SEC2, REG_SEC3, REG_CTRL, REG_CMD,
    REG_IRQ_STATUS, REG_IRQ_CLEAR, REG_IRQ_ENABLE, REG_NONE
  } rtcsa_reg_type;

  typedef struct packed {
    logic awvalid;
    logic [23:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [23:0] araddr;
    logic rready;
  } rtcsa_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtcsa_axi_rsp_type;

endpackage : rtcsa_pkg

// File: design/rtcsa_top.sv
// Second counter with alarm, divider ticks, interrupt flags and AXI4-Lite registers.
// Behaviour
// - 16-bit divider makes 4 Hz and 1 Hz ticks.
// - Seconds counter advances on each 1 Hz tick.
// - Counters read-only; zeroed only by clear command.
// - Alarm equal to seconds sets alarm flag.
// - Seconds reads; writes at same address load alarm.
// - Four bytes hold bits 7:0 through 29:24.
// - Second enable sets second flag every second.
// - Second flag held until software clears it.
// - Alarm flag held until software clears it.
// - Quarter interrupt has its own enable bit.
// - Counting always runs, no enable control.
// - Slow crystal clock offered as system clock source.
// - Seconds bytes read zero after reset.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module rtcsa_top (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus.
  input wire rtcsa_pkg::rtcsa_axi_req_type axi_req,
  output rtcsa_pkg::rtcsa_axi_rsp_type axi_rsp,
  // Oscillator pin and clock source offer.
  input wire logic slow_crystal_clock,
  output logic slow_clock_source,
  // Interrupt.
  output logic irq
);

  function automatic rtcsa_pkg::rtcsa_reg_type decode_reg(input logic [23:0] addr);
    logic [21:0] idx;
    idx = addr[23:2];
    case (idx)
      rtcsa_pkg::IDX_SEC_BYTE0: decode_reg = rtcsa_pkg::REG_SEC0;
      rtcsa_pkg::IDX_SEC_BYTE1: decode_reg = rtcsa_pkg::REG_SEC1;
      rtcsa_pkg::IDX_SEC_BYTE2: decode_reg = rtcsa_pkg::REG_SEC2;
      rtcsa_pkg::IDX_SEC_BYTE3: decode_reg = rtcsa_pkg::REG_SEC3;
      rtcsa_pkg::IDX_CTRL: decode_reg = rtcsa_pkg::REG_CTRL;
      rtcsa_pkg::IDX_CMD: decode_reg = rtcsa_pkg::REG_CMD;
      rtcsa_pkg::IDX_IRQ_STATUS: decode_reg = rtcsa_pkg::REG_IRQ_STATUS;
      rtcsa_pkg::IDX_IRQ_CLEAR: decode_reg = rtcsa_pkg::REG_IRQ_CLEAR;
      rtcsa_pkg::IDX_IRQ_ENABLE: decode_reg = rtcsa_pkg::REG_IRQ_ENABLE;
      default: decode_reg = rtcsa_pkg::REG_NONE;
    endcase
  endfunction : decode_reg

  // Oscillator synchroniser and edge detector.
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_rise;

  // Counting chain.
  logic [rtcsa_pkg::DIV_WIDTH-1:0] tick_divider_count_q;
  logic [rtcsa_pkg::SEC_WIDTH-1:0] seconds_count_q;
  logic [rtcsa_pkg::SEC_WIDTH-1:0] alarm_value_q;
  logic quarter_tick;
  logic second_tick;
  logic alarm_match;
  logic alarm_match_q;

  // Control and interrupt state.
  logic second_irq_enable_q;
  logic alarm_irq_enable_q;
  logic quarter_second_irq_enable_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_enable_q;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [2:0] irq_enable_d;

  // Bus state.
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_full_q;
  logic w_full_q;
  logic [23:0] aw_addr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic do_write;
  logic wr_hit;
  logic cmd_clear;
  rtcsa_pkg::rtcsa_reg_type wr_reg;
  rtcsa_pkg::rtcsa_reg_type rd_reg;
  logic [7:0] rd_byte;
  logic [7:0] ctrl_view;
  logic irq_q;
  logic slow_clock_source_q;

  // The first stage feeds only the second; the edge is taken between stages two and three.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= slow_crystal_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_rise = osc_s2_q & ~osc_s3_q;

  // The retimed crystal clock is handed to the system clock selector.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slow_clock_source_q <= 1'b0;
    end else begin
      slow_clock_source_q <= osc_s2_q;
    end
  end

  // One tick every 8192 oscillator edges gives 4 Hz; every 32768 edges gives 1 Hz.
  assign quarter_tick = osc_rise && (&tick_divider_count_q[rtcsa_pkg::QUARTER_BITS-1:0]);
  assign second_tick = osc_rise && (&tick_divider_count_q[rtcsa_pkg::SECOND_BITS-1:0]);

  assign wr_reg = decode_reg(aw_addr_q);
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit = do_write && wlane_q;
  assign cmd_clear = wr_hit && (wr_reg == rtcsa_pkg::REG_CMD) && wbyte_q[rtcsa_pkg::CMD_CLEAR];

  // The divider has no enable; only the clear command stops its progress.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_divider_count_q <= '0;
    end else if (cmd_clear) begin
      tick_divider_count_q <= '0;
    end else if (osc_rise) begin
      tick_divider_count_q <= tick_divider_count_q + 16'h0001;
    end
  end

  // Software writes reach the seconds counter only through the clear command; clear wins over a tick.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seconds_count_q <= '0;
    end else if (cmd_clear) begin
      seconds_count_q <= '0;
    end else if (second_tick) begin
      seconds_count_q <= seconds_count_q + 30'h00000001;
    end
  end

  // Writes to the seconds addresses land in the alarm, one byte per address.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm_value_q <= rtcsa_pkg::ALARM_RESET;
    end else if (wr_hit) begin
      case (wr_reg)
        rtcsa_pkg::REG_SEC0: alarm_value_q[7:0] <= wbyte_q;
        rtcsa_pkg::REG_SEC1: alarm_value_q[15:8] <= wbyte_q;
        rtcsa_pkg::REG_SEC2: alarm_value_q[23:16] <= wbyte_q;
        rtcsa_pkg::REG_SEC3: alarm_value_q[29:24] <= wbyte_q[5:0];
        default: alarm_value_q <= alarm_value_q;
      endcase
    end
  end

  // Comparison runs every cycle; the remembered match stops a repeat while equality lasts.
  assign alarm_match = (seconds_count_q == alarm_value_q);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Counter and alarm both reset to zero, so the remembered match starts set.
      alarm_match_q <= 1'b1;
    end else begin
      alarm_match_q <= alarm_match;
    end
  end

  // Control register: enables are stored, flag bits written as one clear the flag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      second_irq_enable_q <= rtcsa_pkg::CTRL_RESET[rtcsa_pkg::CTRL_SEC_EN];
      alarm_irq_enable_q <= rtcsa_pkg::CTRL_RESET[rtcsa_pkg::CTRL_ALM_EN];
      quarter_second_irq_enable_q <= rtcsa_pkg::CTRL_RESET[rtcsa_pkg::CTRL_QTR_EN];
    end else if (wr_hit && (wr_reg == rtcsa_pkg::REG_CTRL)) begin
      second_irq_enable_q <= wbyte_q[rtcsa_pkg::CTRL_SEC_EN];
      alarm_irq_enable_q <= wbyte_q[rtcsa_pkg::CTRL_ALM_EN];
      quarter_second_irq_enable_q <= wbyte_q[rtcsa_pkg::CTRL_QTR_EN];
    end
  end

  assign flag_set[rtcsa_pkg::IRQ_SEC] = second_tick && second_irq_enable_q;
  assign flag_set[rtcsa_pkg::IRQ_ALM] = alarm_match && !alarm_match_q && alarm_irq_enable_q;
  assign flag_set[rtcsa_pkg::IRQ_QTR] = quarter_tick && quarter_second_irq_enable_q;

  always_comb begin
    flag_clr = 3'h0;
    if (wr_hit && (wr_reg == rtcsa_pkg::REG_CTRL)) begin
      flag_clr[rtcsa_pkg::IRQ_SEC] = wbyte_q[rtcsa_pkg::CTRL_SEC_FLAG];
      flag_clr[rtcsa_pkg::IRQ_ALM] = wbyte_q[rtcsa_pkg::CTRL_ALM_FLAG];
      flag_clr[rtcsa_pkg::IRQ_QTR] = wbyte_q[rtcsa_pkg::CTRL_QTR_FLAG];
    end else if (wr_hit && (wr_reg == rtcsa_pkg::REG_IRQ_CLEAR)) begin
      flag_clr = wbyte_q[2:0];
    end
  end

  // Flags are sticky; a set in the same cycle as a clear is kept.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= 3'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_enable_q <= rtcsa_pkg::IRQ_EN_RESET;
    end else if (wr_hit && (wr_reg == rtcsa_pkg::REG_IRQ_ENABLE)) begin
      irq_enable_q <= wbyte_q[2:0];
    end
  end

  // The level uses the enable written in the same cycle, so it never lags the enable register.
  assign irq_enable_d = (wr_hit && (wr_reg == rtcsa_pkg::REG_IRQ_ENABLE)) ? wbyte_q[2:0] : irq_enable_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((irq_status_q & ~flag_clr) | flag_set) & irq_enable_d);
    end
  end

  // Write address and data are captured independently, in either order.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      aw_addr_q <= 24'h000000;
    end else if (axi_req.awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      aw_addr_q <= axi_req.awaddr;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (bvalid_q && axi_req.bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (axi_req.wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wbyte_q <= axi_req.wdata[7:0];
      wlane_q <= axi_req.wstrb[0];
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (bvalid_q && axi_req.bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= rtcsa_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_reg == rtcsa_pkg::REG_NONE) ? rtcsa_pkg::RESP_SLVERR : rtcsa_pkg::RESP_OKAY;
    end else if (bvalid_q && axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Reads come from the same clock domain; each byte is sampled on its own, so a tick between byte reads can tear the count.
  assign rd_reg = decode_reg(axi_req.araddr);
  assign ctrl_view = {second_irq_enable_q, alarm_irq_enable_q, irq_status_q[rtcsa_pkg::IRQ_SEC],
                      irq_status_q[rtcsa_pkg::IRQ_ALM], quarter_second_irq_enable_q,
                      irq_status_q[rtcsa_pkg::IRQ_QTR], 2'h0};

  always_comb begin
    case (rd_reg)
      rtcsa_pkg::REG_SEC0: rd_byte = seconds_count_q[7:0];
      rtcsa_pkg::REG_SEC1: rd_byte = seconds_count_q[15:8];
      rtcsa_pkg::REG_SEC2: rd_byte = seconds_count_q[23:16];
      rtcsa_pkg::REG_SEC3: rd_byte = {2'h0, seconds_count_q[29:24]};
      rtcsa_pkg::REG_CTRL: rd_byte = ctrl_view;
      rtcsa_pkg::REG_IRQ_STATUS: rd_byte = {5'h00, irq_status_q};
      rtcsa_pkg::REG_IRQ_ENABLE: rd_byte = {5'h00, irq_enable_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= rtcsa_pkg::RESP_OKAY;
    end else if (axi_req.arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= (rd_reg == rtcsa_pkg::REG_NONE) ? rtcsa_pkg::RESP_SLVERR : rtcsa_pkg::RESP_OKAY;
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign axi_rsp = '{
    awready: awready_q,
    wready: wready_q,
    bvalid: bvalid_q,
    bresp: bresp_q,
    arready: arready_q,
    rvalid: rvalid_q,
    rdata: rdata_q,
    rresp: rresp_q
  };
  assign irq = irq_q;
  assign slow_clock_source = slow_clock_source_q;

  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  tick_nesting_a: assert property (second_tick |-> quarter_tick)
    else $error("second tick without quarter tick");
  second_advance_a: assert property (second_tick && !cmd_clear |=>
    seconds_count_q == $past(seconds_count_q) + 30'h00000001)
    else $error("seconds counter did not advance on tick");
  count_hold_a: assert property (!second_tick && !cmd_clear |=> $stable(seconds_count_q))
    else $error("seconds counter changed without tick");
  clear_cmd_a: assert property (cmd_clear |=> seconds_count_q == 30'h0 && tick_divider_count_q == 16'h0)
    else $error("clear command did not zero counters");
  alarm_set_a: assert property (alarm_match && !alarm_match_q && alarm_irq_enable_q
    |=> irq_status_q[rtcsa_pkg::IRQ_ALM])
    else $error("alarm match did not set alarm flag");
  alarm_once_a: assert property (alarm_match_q && !irq_status_q[rtcsa_pkg::IRQ_ALM]
    |=> !irq_status_q[rtcsa_pkg::IRQ_ALM] || !$past(alarm_match) || $past(!alarm_match_q))
    else $error("alarm flag set again during lasting match");
  alarm_write_a: assert property (wr_hit && wr_reg == rtcsa_pkg::REG_SEC3 && !second_tick && !cmd_clear
    |=> $stable(seconds_count_q) && alarm_value_q[29:24] == $past(wbyte_q[5:0]))
    else $error("alarm write disturbed counter or missed alarm");
  second_flag_a: assert property (second_tick && second_irq_enable_q |=> irq_status_q[rtcsa_pkg::IRQ_SEC])
    else $error("second flag not set on tick");
  flag_sticky_a: assert property (irq_status_q[rtcsa_pkg::IRQ_SEC] && !flag_clr[rtcsa_pkg::IRQ_SEC]
    |=> irq_status_q[rtcsa_pkg::IRQ_SEC])
    else $error("second flag dropped without clear");
  alarm_sticky_a: assert property (irq_status_q[rtcsa_pkg::IRQ_ALM] && !flag_clr[rtcsa_pkg::IRQ_ALM]
    |=> irq_status_q[rtcsa_pkg::IRQ_ALM])
    else $error("alarm flag dropped without clear");
  quarter_gate_a: assert property (quarter_tick && !quarter_second_irq_enable_q &&
    !irq_status_q[rtcsa_pkg::IRQ_QTR] |=> !irq_status_q[rtcsa_pkg::IRQ_QTR])
    else $error("quarter flag set while disabled");
  quarter_flag_a: assert property (quarter_tick && quarter_second_irq_enable_q
    |=> irq_status_q[rtcsa_pkg::IRQ_QTR])
    else $error("quarter flag not set on tick");
  read_top_a: assert property (axi_req.arvalid && arready_q && rd_reg == rtcsa_pkg::REG_SEC3
    |=> rvalid_q && rdata_q[7:6] == 2'h0 && rdata_q[5:0] == $past(seconds_count_q[29:24]))
    else $error("top seconds byte read wrong");
  irq_level_a: assert property (irq_q == |(irq_status_q & irq_enable_q))
    else $error("interrupt level differs from enabled flags");

  alarm_hit_c: cover property (flag_set[rtcsa_pkg::IRQ_ALM] ##1 irq_q);
  clear_cmd_c: cover property (cmd_clear ##1 seconds_count_q == 30'h0);
  flag_race_c: cover property (flag_set[rtcsa_pkg::IRQ_SEC] && flag_clr[rtcsa_pkg::IRQ_SEC]);

endmodule : rtcsa_top

// File: verif/rtcsa_tb.sv
// Self-checking bench for the second and alarm counter block, compared with an integer model.
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic slow_crystal_clock = 1'h0;
  logic slow_clock_source;
  logic irq;
  rtcsa_pkg::rtcsa_axi_req_type req = '0;
  rtcsa_pkg::rtcsa_axi_rsp_type rsp;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 65;
  int sec_m = 0;
  int alarm_m = 0;
  int rise_m = 0;
  int en_m = 0;
  int flags_m = 0;
  int irqen_m = 0;
  bit match_m = 1'h1;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [31:0] v;

  rtcsa_top rtcsa_top_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .axi_req(req),
    .axi_rsp(rsp),
    .slow_crystal_clock(slow_crystal_clock),
    .slow_clock_source(slow_clock_source),
    .irq(irq)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic results;
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    n_errors++;
    $display("unexpected %s: expected an answer seen none", what);
    results();
  endtask : hang

  task automatic wr(input logic [21:0] idx, input logic [7:0] d, input logic [3:0] st = 4'h1,
                    input logic [1:0] er = rtcsa_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.awvalid <= 1'h1;
    req.awaddr <= {idx, 2'h0};
    req.wvalid <= 1'h1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= st;
    req.bready <= 1'h1;
    forever begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid === 1'h1) begin
        resp = rsp.bresp;
        req.bready <= 1'h0;
        break;
      end
      n++;
      if (n > 40) hang("write response");
    end
    chk("write response", er, resp);
  endtask : wr

  task automatic rdt(input logic [21:0] idx, input logic [1:0] er = rtcsa_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.arvalid <= 1'h1;
    req.araddr <= {idx, 2'h0};
    req.rready <= 1'h1;
    forever begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid === 1'h1) begin
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'h0;
        break;
      end
      n++;
      if (n > 40) hang("read response");
    end
    chk("read response", er, resp);
  endtask : rdt

  function automatic logic [21:0] sec_idx(input int k);
    return (k == 0) ? rtcsa_pkg::IDX_SEC_BYTE0 : rtcsa_pkg::IDX_SEC_BYTE1 + 22'(k - 1);
  endfunction : sec_idx

  function automatic void upd_match();
    bit m;
    m = (sec_m == alarm_m);
    if (m && !match_m && en_m[6]) flags_m |= 2;
    match_m = m;
  endfunction : upd_match

  function automatic void tick_m();
    rise_m++;
    if (rise_m % 32'h2000 == 0 && en_m[3]) flags_m |= 4;
    if (rise_m % 32'h8000 == 0) begin
      sec_m = (sec_m + 1) & 32'h3fffffff;
      if (en_m[7]) flags_m |= 1;
      upd_match();
    end
  endfunction : tick_m

  function automatic int ctrl_m();
    return en_m | ((flags_m & 1) << 5) | ((flags_m & 2) << 3) | (flags_m & 4);
  endfunction : ctrl_m

  // Two system clocks per oscillator period keep a full second within the run budget.
  task automatic rises(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      slow_crystal_clock <= 1'h1;
      @(posedge sys_clk);
      slow_crystal_clock <= 1'h0;
      tick_m();
    end
  endtask : rises

  task automatic alarm_byte(input int k, input logic [7:0] b);
    wr(sec_idx(k), b);
    alarm_m = ((alarm_m & ~(32'hff << (8 * k))) | (int'(b) << (8 * k))) & 32'h3fffffff;
    upd_match();
  endtask : alarm_byte

  task automatic set_ctrl(input logic [7:0] b);
    wr(rtcsa_pkg::IDX_CTRL, b);
    en_m = b & 8'hc8;
    flags_m &= ~((b[5] ? 1 : 0) | (b[4] ? 2 : 0) | (b[2] ? 4 : 0));
  endtask : set_ctrl

  task automatic set_irqen(input logic [7:0] b);
    wr(rtcsa_pkg::IDX_IRQ_ENABLE, b);
    irqen_m = b & 8'h07;
  endtask : set_irqen

  task automatic clr(input logic [7:0] b);
    wr(rtcsa_pkg::IDX_IRQ_CLEAR, b);
    flags_m &= ~int'(b);
  endtask : clr

  task automatic check_all;
    repeat (6) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      rdt(sec_idx(k));
      chk("seconds byte", (sec_m >> (8 * k)) & 32'hff, rd);
    end
    rdt(rtcsa_pkg::IDX_CTRL);
    chk("control", ctrl_m(), rd);
    rdt(rtcsa_pkg::IDX_IRQ_STATUS);
    chk("status", flags_m, rd);
    chk("irq", ((flags_m & irqen_m) != 0) ? 1 : 0, irq);
  endtask : check_all

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    check_all();
    rdt(rtcsa_pkg::IDX_IRQ_ENABLE);
    chk("irq enable", 32'h0, rd);
    rdt(rtcsa_pkg::IDX_CMD);
    chk("command", 32'h0, rd);
    rdt(22'h001234, rtcsa_pkg::RESP_SLVERR);
    chk("unmapped read", 32'h0, rd);
    wr(22'h001234, 8'hff, 4'h1, rtcsa_pkg::RESP_SLVERR);
    wr(rtcsa_pkg::IDX_CTRL, 8'hc8, 4'h0);
    wr(rtcsa_pkg::IDX_IRQ_STATUS, 8'h07);
    set_ctrl(8'h40);
    set_irqen(8'h02);
    v = $random(seed);
    for (int k = 0; k < 4; k++) alarm_byte(k, v[8*k+:8] | 8'h01);
    check_all();
    for (int k = 3; k >= 0; k--) alarm_byte(k, 8'h00);
    check_all();
    repeat (50) @(posedge sys_clk);
    set_irqen(8'h00);
    check_all();
    set_irqen(8'h02);
    clr(8'h02);
    check_all();
    alarm_byte(0, 8'h05);
    alarm_byte(0, 8'h00);
    check_all();
    set_ctrl(8'h50);
    check_all();
    alarm_byte(0, 8'h01);
    set_ctrl(8'h48);
    set_irqen(8'h07);
    rises(8191);
    check_all();
    @(posedge sys_clk);
    slow_crystal_clock <= 1'h1;
    repeat (5) @(posedge sys_clk);
    chk("clock source", 32'h1, slow_clock_source);
    slow_crystal_clock <= 1'h0;
    tick_m();
    check_all();
    chk("clock source", 32'h0, slow_clock_source);
    set_ctrl(8'hc4);
    rises(8192);
    check_all();
    set_ctrl(8'hcc);
    rises(16383);
    check_all();
    rises(1);
    check_all();
    repeat (200) @(posedge sys_clk);
    check_all();
    wr(rtcsa_pkg::IDX_CMD, 8'h00);
    check_all();
    wr(rtcsa_pkg::IDX_CMD, 8'h01);
    sec_m = 0;
    rise_m = 0;
    upd_match();
    check_all();
    results();
  end
endmodule : testbench
